// file: logic/analog_select_top.sv
// Analog/digital pin select with direction and gated pin read, Wishbone slave.
// Assumes pins arrive asynchronously; one clock; arst_n may be asynchronous.
`timescale 1ns/1ps
`default_nettype none
module analog_select_top import analog_select_pkg::*; #(
    parameter bit FULL_PINOUT = 1'b1
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [63:0] pin_in,
    output logic [63:0] analog_mode,
    output logic [63:0] pin_oe_n
);
    // Small packages lack the port A and C select bits
    localparam logic [15:0] IMPL_A = FULL_PINOUT ? MASK_A : 16'h0000;
    localparam logic [15:0] IMPL_C = FULL_PINOUT ? MASK_C : 16'h0000;
    localparam logic [63:0] IMPL_ALL = {MASK_D, IMPL_C, MASK_B, IMPL_A};

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [63:0] dir;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;
    logic rst_n;
    logic [63:0] pin_s;
    logic [63:0] level;
    logic req;
    logic wr_commit;
    reg_group_t grp;
    logic [5:0] base;

    sync2 #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
        .clock(clock),
        .rst_n(arst_n),
        .d(1'b1),
        .q(rst_n)
    );

    sync2 #(.WIDTH(64), .INIT(64'h0)) u_pin_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d(pin_in),
        .q(pin_s)
    );

    assign req = wb_cyc_i & wb_stb_i;
    assign grp = decode_group(wb_adr_i);
    assign base = {wb_adr_i[3:2], 4'h0};
    // A write lands at the edge where the master sees ack
    assign wr_commit = req & wb_we_i & st_r.ack;
    // Analog pins never show their level on the read path
    assign level = pin_s & ~analog_mode;

    genvar p;
    generate
        for (p = 0; p < PORT_COUNT; p++) begin : g_port
            select_reg #(.MASK(IMPL_ALL[p*16 +: 16])) u_sel (
                .clock(clock),
                .rst_n(rst_n),
                .wr_en(wr_commit && grp == GRP_ANSEL && wb_adr_i[3:2] == 2'(p)),
                .wr_data(wb_dat_i[15:0]),
                .be(wb_sel_i[1:0]),
                .q(analog_mode[p*16 +: 16])
            );
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = req & ~st_r.ack;
        if (req && !st_r.ack && !wb_we_i) begin
            unique case (grp)
                GRP_ANSEL: st_nxt.dat = {16'h0000, analog_mode[base +: 16]};
                GRP_DIR: st_nxt.dat = {16'h0000, st_r.dir[base +: 16]};
                GRP_LEVEL: st_nxt.dat = {16'h0000, level[base +: 16]};
                GRP_NONE: st_nxt.dat = DAT_RESET;
            endcase
        end
        if (wr_commit && grp == GRP_DIR) begin
            st_nxt.dir[base +: 16] = merge16(st_r.dir[base +: 16], wb_dat_i[15:0],
                                             wb_sel_i[1:0]);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r.ack <= 1'b0;
            st_r.dat <= DAT_RESET;
            st_r.dir <= {PORT_COUNT{DIR_RESET}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;
    // Direction 1 is input, so the driver is off
    assign pin_oe_n = st_r.dir;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    ack_one_cycle_a: assert property (
        req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after one cycle");

    analog_read_zero_a: assert property (
        wb_ack_o && !wb_we_i && decode_group(wb_adr_i) == GRP_LEVEL
        |-> (wb_dat_o[15:0] & $past(analog_mode[{wb_adr_i[3:2], 4'h0} +: 16]))
            == 16'h0000)
        else $error("analog pin level leaked on read");

    analog_input_zero_a: assert property (
        wb_ack_o && !wb_we_i && decode_group(wb_adr_i) == GRP_LEVEL
        |-> (wb_dat_o[15:0] & $past(analog_mode[{wb_adr_i[3:2], 4'h0} +: 16])
             & $past(pin_oe_n[{wb_adr_i[3:2], 4'h0} +: 16])) == 16'h0000)
        else $error("analog input did not read zero");

    digital_read_pass_a: assert property (
        wb_ack_o && !wb_we_i && decode_group(wb_adr_i) == GRP_LEVEL
        |-> wb_dat_o == {16'h0000, $past(level[{wb_adr_i[3:2], 4'h0} +: 16])})
        else $error("digital pin level not returned");

    select_reset_a: assert property (
        $rose(rst_n) |-> analog_mode == IMPL_ALL)
        else $error("select bits not set after reset");

    select_unimpl_a: assert property (
        wb_ack_o && !wb_we_i && decode_group(wb_adr_i) == GRP_ANSEL
        |-> (wb_dat_o & ~{16'h0000, IMPL_ALL[{wb_adr_i[3:2], 4'h0} +: 16]})
            == 32'h0000_0000)
        else $error("unimplemented select position read nonzero");

    port_a_mask_a: assert property (
        (analog_mode[15:0] & ~IMPL_A) == 16'h0000)
        else $error("port A holds bits outside 7:6");

    port_b_write_a: assert property (
        wr_commit && grp == GRP_ANSEL && wb_adr_i[3:2] == 2'd1 && wb_sel_i[1:0] == 2'b11
        |=> analog_mode[31:16] == $past(wb_dat_i[15:0]))
        else $error("port B select write not stored");

    port_c_mask_a: assert property (
        (analog_mode[47:32] & ~IMPL_C) == 16'h0000)
        else $error("port C holds bits outside bit 4");

    port_d_mask_a: assert property (
        (analog_mode[63:48] & ~MASK_D) == 16'h0000)
        else $error("port D holds bits outside 11,10,7,6");

    dir_reset_a: assert property (
        $rose(rst_n) |-> pin_oe_n == {PORT_COUNT{DIR_RESET}})
        else $error("pins not inputs after reset");

    no_write_effect_a: assert property (
        !wr_commit |=> $stable(analog_mode) && $stable(pin_oe_n))
        else $error("register changed without a committed write");

    select_write_c: cover property (wr_commit && grp == GRP_ANSEL);
    level_read_c: cover property (wb_ack_o && !wb_we_i && grp == GRP_LEVEL);
    dir_write_c: cover property (wr_commit && grp == GRP_DIR);
    unmapped_c: cover property (wb_ack_o && grp == GRP_NONE);
endmodule : analog_select_top
`default_nettype wire

// file: logic/analog_select_pkg.sv
// Constants, register map and helpers for the pin analog/digital select block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
// Notes on behaviour
// - Select bit 1 makes pin analog, read blocked
// - Select bit 0 makes pin digital, read allowed
// - Implemented select bits read/write, power-on value 1
// - Unimplemented select positions always read zero
// - Port A implements only bits 7 and 6
// - Port B implements all sixteen select bits
// - Port C implements only bit 4
// - Port D implements bits 11,10,7,6 only
// - Analog input pins read as 0
// - Direction 1 means input; inputs after reset
package analog_select_pkg;

    localparam int PORT_COUNT = 4;
    localparam int PORT_WIDTH = 16;
    localparam int ADR_WIDTH = 8;

    // Byte addresses of the register groups, one word per port
    localparam logic [7:0] ANSEL_BASE = 8'h00;
    localparam logic [7:0] DIR_BASE = 8'h10;
    localparam logic [7:0] LEVEL_BASE = 8'h20;

    // Implemented select positions per port
    localparam logic [15:0] MASK_A = 16'h00C0;
    localparam logic [15:0] MASK_B = 16'hFFFF;
    localparam logic [15:0] MASK_C = 16'h0010;
    localparam logic [15:0] MASK_D = 16'h0CC0;

    // Power-on values
    localparam logic [15:0] DIR_RESET = 16'hFFFF;
    localparam logic [31:0] DAT_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        GRP_ANSEL,
        GRP_DIR,
        GRP_LEVEL,
        GRP_NONE
    } reg_group_t;

    // Group of a byte address
    function automatic reg_group_t decode_group(input logic [7:0] adr);
        if (adr[7:4] == ANSEL_BASE[7:4]) begin
            decode_group = GRP_ANSEL;
        end else if (adr[7:4] == DIR_BASE[7:4]) begin
            decode_group = GRP_DIR;
        end else if (adr[7:4] == LEVEL_BASE[7:4]) begin
            decode_group = GRP_LEVEL;
        end else begin
            decode_group = GRP_NONE;
        end
    endfunction : decode_group

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0] be);
        merge16 = old_v;
        if (be[0]) begin
            merge16[7:0] = new_v[7:0];
        end
        if (be[1]) begin
            merge16[15:8] = new_v[15:8];
        end
    endfunction : merge16

endpackage : analog_select_pkg

// file: logic/sync2.sv
// Two-flop synchroniser for a vector of levels.
// Assumes d comes from outside the clock domain; only q may be read.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= {INIT, INIT};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule : sync2
`default_nettype wire

// file: logic/select_reg.sv
// One analog-select register: byte-lane writes, fixed implemented mask.
// Assumes wr_en is a single-cycle strobe from the bus slave.
`timescale 1ns/1ps
`default_nettype none
module select_reg import analog_select_pkg::*; #(
    parameter logic [15:0] MASK = 16'hFFFF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] be,
    output logic [15:0] q
);
    typedef struct packed {
        logic [15:0] sel;
    } sel_state_t;

    sel_state_t st_r;
    sel_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (wr_en) begin
            st_nxt.sel = merge16(st_r.sel, wr_data, be) & MASK;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r.sel <= MASK;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.sel;

    unimpl_stay_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        (q & ~MASK) == 16'h0000)
        else $error("unimplemented select bit set");
endmodule : select_reg
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the analog/digital pin select block.
// Assumes the block's single-cycle Wishbone ack and its fixed register offsets.
`timescale 1ns/1ps
`default_nettype none
module tb_top import analog_select_pkg::*;;
    localparam logic [63:0] MASK_ALL = {MASK_D, MASK_C, MASK_B, MASK_A};
    localparam logic [63:0] PAT = 64'hFFFF_3CF0_A5C3_F0F0;
    logic clock;
    logic arst_n;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [63:0] pin_in;
    logic [63:0] analog_mode;
    logic [63:0] pin_oe_n;
    logic [31:0] rd;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;

    analog_select_top #(.FULL_PINOUT(1'b1)) analog_select_top_i (
        .clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pin_in(pin_in), .analog_mode(analog_mode),
        .pin_oe_n(pin_oe_n)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic summarize();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // A hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // One classic cycle; request held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                        input logic [1:0] be, output logic [31:0] r);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= {2'b00, be};
        dat_w <= {16'h0000, d};
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic reset_dut();
        arst_n <= 1'b0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask : reset_dut

    initial begin
        arst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat_w = 32'h0000_0000;
        pin_in = 64'h0000_0000_0000_0000;
        reset_dut();
        check(analog_mode, MASK_ALL);
        check(pin_oe_n, {64{1'b1}});
        pin_in <= PAT;
        for (int p = 0; p < 4; p++) begin
            xfer(1'b0, 8'(p * 4), 16'h0000, 2'b11, rd);
            check(rd, {48'h0, MASK_ALL[p*16 +: 16]});
            xfer(1'b0, 8'(8'h10 + p * 4), 16'h0000, 2'b11, rd);
            check(rd, 64'h0000_FFFF);
            xfer(1'b0, 8'(8'h20 + p * 4), 16'h0000, 2'b11, rd);
            check(rd, {48'h0, PAT[p*16 +: 16] & ~MASK_ALL[p*16 +: 16]});
        end
        for (int p = 0; p < 4; p++) begin
            xfer(1'b1, 8'(p * 4), 16'h0000, 2'b11, rd);
            xfer(1'b0, 8'(p * 4), 16'h0000, 2'b11, rd);
            check(rd, 64'h0);
            xfer(1'b0, 8'(8'h20 + p * 4), 16'h0000, 2'b11, rd);
            check(rd, {48'h0, PAT[p*16 +: 16]});
        end
        @(posedge clock);
        check(analog_mode, 64'h0);
        xfer(1'b1, 8'h04, 16'hFFFF, 2'b01, rd);
        xfer(1'b0, 8'h04, 16'h0000, 2'b11, rd);
        check(rd, 64'h0000_00FF);
        xfer(1'b0, 8'h24, 16'h0000, 2'b11, rd);
        check(rd, {48'h0, PAT[31:16] & 16'hFF00});
        for (int p = 0; p < 4; p++) begin
            xfer(1'b1, 8'(p * 4), 16'hFFFF, 2'b11, rd);
            xfer(1'b0, 8'(p * 4), 16'h0000, 2'b11, rd);
            check(rd, {48'h0, MASK_ALL[p*16 +: 16]});
        end
        @(posedge clock);
        check(analog_mode, MASK_ALL);
        xfer(1'b1, 8'h10, 16'h0000, 2'b11, rd);
        @(posedge clock);
        check(pin_oe_n, {48'hFFFF_FFFF_FFFF, 16'h0000});
        xfer(1'b1, 8'h20, 16'h1234, 2'b11, rd);
        xfer(1'b0, 8'h20, 16'h0000, 2'b11, rd);
        check(rd, {48'h0, PAT[15:0] & ~MASK_A});
        xfer(1'b1, 8'h40, 16'hFFFF, 2'b11, rd);
        xfer(1'b0, 8'h40, 16'h0000, 2'b11, rd);
        check(rd, 64'h0);
        xfer(1'b1, 8'h0C, 16'h0000, 2'b11, rd);
        reset_dut();
        check(analog_mode, MASK_ALL);
        check(pin_oe_n, {64{1'b1}});
        summarize();
    end
endmodule : tb_top
`default_nettype wire
